// *** rate_limiter.sv ***
// Contract
// - Error set holds exactly one one-byte errored-parameter item
// - Error set holds exactly one one-byte error code
// - Error code zero is never valid
// - At most one zero-terminated error message
// - Whole encoding shorter than 256 bytes
// - Each QoS type at most once
// - Priority 0..7, absent means 0
// - Priority favours delay, overrides nothing else
// - Priority steers contention request choice
// - Count bytes after header check through CRC
// - Bytes per interval within T*R/8 plus B
// - Zero or absent rate means no limit
// - Never request beyond the interval limit
// - Hold over-limit packets until conforming
// - Headend may drop over-limit data
// - Report violations, allow policing margin
// - Rate is four bytes, bit per second
// - Downstream queues excess until bound allows
// - Bucket minimum 1522, default 3044 bytes
// - Bucket ignored unless rate non-zero
// - Error encoding excludes QoS parameters
//
// Chosen here: register access over APB and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none

module rate_limiter
  import rate_pkg::*;
#(
  parameter int unsigned POLICE_MARGIN = 64  // Policing slack, bytes
) (
  input  wire logic        CLK_I,
  input  wire logic        RSTN_I,
  input  wire logic        CE_I,         // Freezes all state when low
  // APB slave
  input  wire logic        PSEL_I,
  input  wire logic        PENABLE_I,
  input  wire logic        PWRITE_I,
  input  wire logic [7:0]  PADDR_I,
  input  wire logic [31:0] PWDATA_I,
  output logic [31:0]      PRDATA_O,
  output logic             PREADY_O,
  output logic             PSLVERR_O,
  // Encoding byte stream
  input  wire logic        TLV_VALID_I,
  input  wire logic [7:0]  TLV_DATA_I,
  input  wire logic        TLV_LAST_I,
  output logic             TLV_DONE_O,
  output logic [7:0]       TLV_ERR_O,
  // Packet or request admission
  input  wire logic        PKT_VALID_I,
  input  wire logic [15:0] PKT_LEN_I,    // Bytes after header check to CRC
  output logic             PKT_READY_O,
  output logic             PKT_DROP_O,
  output logic             VIOL_O,
  output logic [2:0]       PRIO_O
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic [2:0]  ctrl;       // Control bits
    logic [31:0] rate;       // Sustained rate, bit/s
    logic [31:0] burst;      // Bucket size, bytes
    logic [2:0]  prio;       // Flow priority
    logic        clamp;      // Bucket write raised to minimum
    logic [63:0] credit;     // Byte credit in fine units
    logic [31:0] viol;       // Violation count
    logic        pready;     // APB answer
    logic [31:0] prdata;
    logic        pslverr;
    logic        pkt_ready;  // Admission pulse
    logic        pkt_drop;   // Discard pulse
    logic        viol_p;     // Violation pulse
  } lim_st_t;

  lim_st_t    s_q, s_d;     // Registered state and next value
  parse_res_t res;          // Parser result
  logic [63:0] cap;         // Bucket size in fine units
  logic [63:0] cost;        // Packet length in fine units
  logic [63:0] margin;      // Policing slack in fine units
  logic [63:0] sum;         // Credit after refill
  logic        limit_on;    // Limit is enforced
  logic        reload;      // Refill bucket after reconfiguration
  logic        clamp_set;   // Autoload raised the bucket this cycle
  logic        hit;         // Address decodes
  logic [31:0] rd;          // Read mux
  logic [31:0] bw;          // Clamped bucket value

  // ****************************************************************
  // Encoding checker
  // ****************************************************************
  tlv_check u_check (
    .clk_i   (CLK_I),
    .rstn_i  (RSTN_I),
    .ce_i    (CE_I),
    .valid_i (TLV_VALID_I),
    .data_i  (TLV_DATA_I),
    .last_i  (TLV_LAST_I),
    .res_o   (res)
  );

  // ****************************************************************
  // Read mux and decode
  // ****************************************************************
  always_comb begin
    hit = 1'b1;
    rd  = '0;
    case (PADDR_I)
      // Control bits
      ADDR_CTRL:   rd = 32'(s_q.ctrl);
      // Rate and bucket
      ADDR_RATE:   rd = s_q.rate;
      ADDR_BURST:  rd = s_q.burst;
      // Priority
      ADDR_PRIO:   rd = 32'(s_q.prio);
      // Status: clamp flag, last parse outcome
      ADDR_STATUS: begin
        rd[ST_CLAMP] = s_q.clamp;
        rd[ST_OK]    = (res.err == '0);
        rd[ST_ERR_LSB +: 8] = res.err;
      end
      // Whole bytes of credit
      ADDR_CREDIT: rd = 32'(s_q.credit / SCALE);
      // Violations seen
      ADDR_VIOL:   rd = s_q.viol;
      // Unmapped
      default:     hit = 1'b0;
    endcase
  end

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    s_d = s_q;
    s_d.pkt_ready = 1'b0;
    s_d.pkt_drop  = 1'b0;
    s_d.viol_p    = 1'b0;
    reload = 1'b0;
    clamp_set = 1'b0;
    bw     = '0;

    // Bucket size and packet cost in credit units
    cap    = 64'(s_q.burst) * SCALE;
    cost   = 64'(PKT_LEN_I) * SCALE;
    margin = 64'(POLICE_MARGIN) * SCALE;

    // Limit only with a non-zero rate; bucket ignored otherwise
    limit_on = s_q.ctrl[CTRL_EN] && (s_q.rate != '0);

    // Refill: R bits per second is R/8 bytes, capped at B
    sum = s_q.credit + 64'(s_q.rate);
    if (limit_on) begin
      s_d.credit = (sum > cap) ? cap : sum;
    end else begin
      // Bucket kept full while unlimited
      s_d.credit = cap;
    end

    // Admission; source holds request until the ready pulse
    if (PKT_VALID_I && !s_q.pkt_ready) begin
      if (!limit_on) begin
        // No maximum enforced
        s_d.pkt_ready = 1'b1;
      end else if (s_d.credit >= cost) begin
        // Conforming: spend credit
        s_d.pkt_ready = 1'b1;
        s_d.credit = s_d.credit - cost;
      end else if (s_q.ctrl[CTRL_POLICE]) begin
        // Policing: take the item, discard unless within slack
        s_d.pkt_ready = 1'b1;
        if (s_d.credit + margin >= cost) begin
          s_d.credit = '0;
        end else begin
          s_d.pkt_drop = 1'b1;
          s_d.viol_p   = 1'b1;
        end
      end
      // Shaping: otherwise wait with ready low until conforming
    end

    // Violation count for the policy function
    if (PSEL_I && PENABLE_I && s_q.pready && PWRITE_I && PADDR_I == ADDR_VIOL) begin
      // Software clear, a same-cycle event still counts
      s_d.viol = '0;
    end
    if (s_d.viol_p) begin
      s_d.viol = s_d.viol + 32'h0000_0001;
    end

    // Load a clean parse result when autoload is set
    if (s_q.ctrl[CTRL_AUTO] && res.done && res.err == '0) begin
      s_d.rate = res.rate_ok ? res.rate : '0;
      if (!res.burst_ok) begin
        // Absent bucket takes the default
        s_d.burst = BURST_DEF;
      end else if (res.burst < BURST_MIN) begin
        s_d.burst = BURST_MIN;
        s_d.clamp = 1'b1;
        clamp_set = 1'b1;
      end else begin
        s_d.burst = res.burst;
      end
      s_d.prio = res.prio;
      reload = 1'b1;
    end

    // APB access phase: one wait state, then answer
    if (PSEL_I && PENABLE_I && !s_q.pready) begin
      s_d.pready  = 1'b1;
      s_d.prdata  = rd;
      s_d.pslverr = !hit;
    end else begin
      s_d.pready  = 1'b0;
      s_d.prdata  = '0;
      s_d.pslverr = 1'b0;
    end

    // APB write takes effect on the answering edge
    if (PSEL_I && PENABLE_I && s_q.pready && PWRITE_I) begin
      case (PADDR_I)
        // Control
        ADDR_CTRL: begin
          s_d.ctrl = PWDATA_I[2:0];
          reload = 1'b1;
        end
        // Rate, four bytes
        ADDR_RATE: begin
          s_d.rate = PWDATA_I;
          reload = 1'b1;
        end
        // Bucket, raised to the minimum
        ADDR_BURST: begin
          bw = (PWDATA_I < BURST_MIN) ? BURST_MIN : PWDATA_I;
          s_d.burst = bw;
          if (PWDATA_I < BURST_MIN) begin
            s_d.clamp = 1'b1;
          end
          reload = 1'b1;
        end
        // Priority
        ADDR_PRIO: begin
          s_d.prio = PWDATA_I[2:0];
        end
        // Write one clears the clamp flag; a same-cycle set wins
        ADDR_STATUS: begin
          if (PWDATA_I[ST_CLAMP]) begin
            s_d.clamp = clamp_set;
          end
        end
        // Others ignored here; ADDR_VIOL clears the count above
        default: begin
          s_d.clamp = s_d.clamp;
        end
      endcase
    end

    // Reconfiguration starts from a full bucket
    if (reload) begin
      s_d.credit = 64'(s_d.burst) * SCALE;
    end
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      s_q        <= '0;
      s_q.burst  <= BURST_DEF;
      s_q.credit <= 64'(BURST_DEF) * SCALE;
    end else if (CE_I) begin
      s_q <= s_d;
    end
  end

  // ****************************************************************
  // Outputs, all from flip-flops
  // ****************************************************************
  assign PRDATA_O    = s_q.prdata;
  assign PREADY_O    = s_q.pready;
  assign PSLVERR_O   = s_q.pslverr;
  assign PKT_READY_O = s_q.pkt_ready;
  assign PKT_DROP_O  = s_q.pkt_drop;
  assign VIOL_O      = s_q.viol_p;
  // Priority for delay, buffering and request choice
  assign PRIO_O      = s_q.prio;
  assign TLV_DONE_O  = res.done;
  assign TLV_ERR_O   = res.err;

endmodule

`default_nettype wire

// *** rate_pkg.sv ***
package rate_pkg;

  // ****************************************************************
  // Clock and credit scaling
  // ****************************************************************
  localparam int unsigned      CLK_PERIOD_NS = 40;                  // 25 MHz clock
  localparam longint unsigned  NS_PER_S      = 64'd1_000_000_000;
  localparam longint unsigned  CLK_HZ        = NS_PER_S / CLK_PERIOD_NS;
  localparam longint unsigned  BITS_PER_BYTE = 64'd8;
  // Credit units per byte: rate in bit/s is added once per cycle
  localparam logic [63:0]      SCALE         = 64'(BITS_PER_BYTE * CLK_HZ);

  // ****************************************************************
  // Register map and fields
  // ****************************************************************
  localparam logic [7:0] ADDR_CTRL   = 8'h00;  // Enable, police, autoload
  localparam logic [7:0] ADDR_RATE   = 8'h04;  // Sustained rate, bit/s
  localparam logic [7:0] ADDR_BURST  = 8'h08;  // Bucket size, bytes
  localparam logic [7:0] ADDR_PRIO   = 8'h0c;  // Flow priority
  localparam logic [7:0] ADDR_STATUS = 8'h10;  // Clamp flag, parse result
  localparam logic [7:0] ADDR_CREDIT = 8'h14;  // Whole bytes of credit
  localparam logic [7:0] ADDR_VIOL   = 8'h18;  // Violation count
  localparam int unsigned CTRL_EN     = 0;
  localparam int unsigned CTRL_POLICE = 1;
  localparam int unsigned CTRL_AUTO   = 2;
  localparam int unsigned ST_CLAMP    = 0;
  localparam int unsigned ST_OK       = 1;
  localparam int unsigned ST_ERR_LSB  = 8;
  localparam logic [31:0] BURST_MIN   = 32'h0000_05f2;  // 1522 bytes
  localparam logic [31:0] BURST_DEF   = 32'h0000_0be4;  // 3044 bytes

  // ****************************************************************
  // Encoding subtypes, lengths and error flags
  // ****************************************************************
  localparam logic [7:0] ST_ERR      = 8'h05;  // Error encoding
  localparam logic [7:0] ST_PRIO     = 8'h07;  // Priority, first QoS type
  localparam logic [7:0] ST_RATE     = 8'h08;
  localparam logic [7:0] ST_BURST    = 8'h09;
  localparam logic [7:0] EST_PARAM   = 8'h01;  // Errored parameter item
  localparam logic [7:0] EST_CODE    = 8'h02;  // Error code item
  localparam logic [7:0] EST_MSG     = 8'h03;  // Error message item
  localparam logic [7:0] LEN_BYTE    = 8'h01;
  localparam logic [7:0] LEN_WORD    = 8'h04;
  localparam logic [7:0] PRIO_MAX    = 8'h07;
  localparam logic [7:0] CODE_OK     = 8'h00;
  localparam logic [8:0] ENC_LAST    = 9'h0ff;  // 256th byte is too long
  localparam int unsigned E_LONG = 0;  // Too long or truncated
  localparam int unsigned E_DUP  = 1;  // Repeated QoS type
  localparam int unsigned E_PARAM = 2; // Errored-parameter item bad
  localparam int unsigned E_CODE = 3;  // Error-code item bad
  localparam int unsigned E_CODE0 = 4; // Success code in error set
  localparam int unsigned E_MSG  = 5;  // Message repeated or unterminated
  localparam int unsigned E_QOSV = 6;  // Bad QoS length or priority
  localparam int unsigned E_MIX  = 7;  // Error set beside QoS params

  typedef enum logic [2:0] {P_TYPE, P_LEN, P_VAL, P_ETYPE, P_ELEN, P_EVAL} phase_t;

  // Parse result handed to the limiter
  typedef struct packed {
    logic        done;
    logic [7:0]  err;
    logic [31:0] rate;
    logic        rate_ok;
    logic [31:0] burst;
    logic        burst_ok;
    logic [2:0]  prio;
  } parse_res_t;

endpackage

// *** tlv_check.sv ***
`timescale 1ns/1ns
`default_nettype none

module tlv_check
  import rate_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       rstn_i,
  input  wire logic       ce_i,
  input  wire logic       valid_i,  // One encoding byte
  input  wire logic [7:0] data_i,
  input  wire logic       last_i,   // Final byte of the encoding
  output parse_res_t      res_o
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    phase_t      ph;        // Parse phase
    logic [7:0]  typ;       // Outer subtype
    logic [7:0]  ityp;      // Inner error item subtype
    logic [7:0]  left;      // Outer value bytes left
    logic [7:0]  ileft;     // Inner value bytes left
    logic [31:0] acc;       // Value shifter
    logic [8:0]  count;     // Bytes seen
    logic [255:0] seen;     // QoS types seen
    logic [1:0]  c1, c2, c3;  // Error item counts
    logic        err_seen;
    logic        qos_seen;
    parse_res_t  w;         // Working result
    parse_res_t  res;       // Published result
  } tlv_st_t;

  tlv_st_t s_q, s_d;
  logic [7:0] b;

  // Next state per byte
  always_comb begin
    s_d = s_q;
    b = data_i;
    s_d.res.done = 1'b0;
    if (valid_i) begin
      if (s_q.count >= ENC_LAST) s_d.w.err[E_LONG] = 1'b1;
      else s_d.count = s_q.count + 9'h001;
      unique case (s_q.ph)
        P_TYPE: begin
          s_d.typ = b;
          if (b >= ST_PRIO) begin
            if (s_q.seen[b]) s_d.w.err[E_DUP] = 1'b1;
            s_d.seen[b] = 1'b1;
            s_d.qos_seen = 1'b1;
          end
          if (b == ST_ERR) s_d.err_seen = 1'b1;
          s_d.ph = P_LEN;
        end
        P_LEN: begin
          s_d.left = b;
          s_d.acc = '0;
          if ((s_q.typ == ST_PRIO && b != LEN_BYTE) ||
              ((s_q.typ == ST_RATE || s_q.typ == ST_BURST) && b != LEN_WORD))
            s_d.w.err[E_QOSV] = 1'b1;
          if (b == '0) s_d.ph = P_TYPE;
          else s_d.ph = (s_q.typ == ST_ERR) ? P_ETYPE : P_VAL;
        end
        P_VAL: begin
          s_d.acc = {s_q.acc[23:0], b};
          s_d.left = s_q.left - 8'h01;
          if (s_q.left == LEN_BYTE) begin
            s_d.ph = P_TYPE;
            if (s_q.typ == ST_PRIO) begin
              if (b > PRIO_MAX) s_d.w.err[E_QOSV] = 1'b1;
              else s_d.w.prio = b[2:0];
            end
            if (s_q.typ == ST_RATE) {s_d.w.rate, s_d.w.rate_ok} = {s_d.acc, 1'b1};
            if (s_q.typ == ST_BURST) {s_d.w.burst, s_d.w.burst_ok} = {s_d.acc, 1'b1};
          end
        end
        P_ETYPE: begin
          s_d.ityp = b;
          s_d.left = s_q.left - 8'h01;
          if (b == EST_PARAM && s_q.c1 != 2'h3) s_d.c1 = s_q.c1 + 2'h1;
          if (b == EST_CODE && s_q.c2 != 2'h3) s_d.c2 = s_q.c2 + 2'h1;
          if (b == EST_MSG && s_q.c3 != 2'h3) s_d.c3 = s_q.c3 + 2'h1;
          s_d.ph = P_ELEN;
          if (s_q.left == LEN_BYTE) s_d.ph = P_TYPE;  // Item cut short
        end
        P_ELEN: begin
          s_d.ileft = b;
          s_d.left = s_q.left - 8'h01;
          if (s_q.ityp == EST_PARAM && b != LEN_BYTE) s_d.w.err[E_PARAM] = 1'b1;
          if (s_q.ityp == EST_CODE && b != LEN_BYTE) s_d.w.err[E_CODE] = 1'b1;
          if (s_q.ityp == EST_MSG && b == '0) s_d.w.err[E_MSG] = 1'b1;
          if (b > s_d.left) s_d.w.err[E_LONG] = 1'b1;
          if (b == '0) s_d.ph = (s_d.left == '0) ? P_TYPE : P_ETYPE;
          else s_d.ph = P_EVAL;
        end
        P_EVAL: begin
          s_d.left = s_q.left - 8'h01;
          s_d.ileft = s_q.ileft - 8'h01;
          if (s_q.ityp == EST_CODE && b == CODE_OK) s_d.w.err[E_CODE0] = 1'b1;
          if (s_q.ityp == EST_MSG && s_q.ileft == LEN_BYTE && b != '0)
            s_d.w.err[E_MSG] = 1'b1;
          if (s_q.ileft == LEN_BYTE || s_q.left == LEN_BYTE)
            s_d.ph = (s_q.left == LEN_BYTE) ? P_TYPE : P_ETYPE;
        end
        default: s_d.ph = P_TYPE;
      endcase
      if (last_i) begin
        s_d.res = s_d.w;
        s_d.res.done = 1'b1;
        if (s_d.ph != P_TYPE) s_d.res.err[E_LONG] = 1'b1;
        if (s_d.err_seen) begin
          if (s_d.c1 != 2'h1) s_d.res.err[E_PARAM] = 1'b1;
          if (s_d.c2 != 2'h1) s_d.res.err[E_CODE] = 1'b1;
          if (s_d.c3 > 2'h1) s_d.res.err[E_MSG] = 1'b1;
          if (s_d.qos_seen) s_d.res.err[E_MIX] = 1'b1;
        end
        s_d.ph = P_TYPE;
        {s_d.count, s_d.seen, s_d.c1, s_d.c2, s_d.c3} = '0;
        {s_d.err_seen, s_d.qos_seen, s_d.w} = '0;
      end
    end
  end

  // State register, frozen while ce_i is low
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) s_q <= '0;
    else if (ce_i) s_q <= s_d;
  end

  assign res_o = s_q.res;

endmodule

`default_nettype wire

// *** rate_limiter_props.sv ***
`timescale 1ns/1ns
`default_nettype none
module rate_limiter_props
  import rate_pkg::*;
#(
  parameter int unsigned POLICE_MARGIN = 64  // Policing slack, bytes
) (
  input wire logic        CLK_I,
  input wire logic        RSTN_I,
  input wire logic        CE_I,
  input wire logic        PSEL_I,
  input wire logic        PENABLE_I,
  input wire logic        PWRITE_I,
  input wire logic [7:0]  PADDR_I,
  input wire logic [31:0] PWDATA_I,
  input wire logic [31:0] PRDATA_O,
  input wire logic        PREADY_O,
  input wire logic        PSLVERR_O,
  input wire logic        TLV_VALID_I,
  input wire logic [7:0]  TLV_DATA_I,
  input wire logic        TLV_LAST_I,
  input wire logic        TLV_DONE_O,
  input wire logic [7:0]  TLV_ERR_O,
  input wire logic        PKT_VALID_I,
  input wire logic [15:0] PKT_LEN_I,
  input wire logic        PKT_READY_O,
  input wire logic        PKT_DROP_O,
  input wire logic        VIOL_O,
  input wire logic [2:0]  PRIO_O
);
  // ************************************************
  // Port relations
  // ************************************************
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RSTN_I);
  // Answer one cycle after first access cycle
  property p_apb_ans; PSEL_I && PENABLE_I && !PREADY_O && CE_I |=> PREADY_O; endproperty
  a_apb_ans: assert property (p_apb_ans) else $error("apb answer late");
  property p_err_rdy; PSLVERR_O |-> PREADY_O; endproperty
  a_err_rdy: assert property (p_err_rdy) else $error("slverr without ready");
  property p_rd_idle; !PREADY_O |-> PRDATA_O == 32'h0; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside answer");
  // Result one cycle after the final byte
  property p_done_time; TLV_VALID_I && TLV_LAST_I && CE_I |=> TLV_DONE_O ##1 !TLV_DONE_O; endproperty
  a_done_time: assert property (p_done_time) else $error("parse done late");
  property p_done_cause; $rose(TLV_DONE_O) |-> $past(TLV_VALID_I && TLV_LAST_I); endproperty
  a_done_cause: assert property (p_done_cause) else $error("parse done unasked");
  property p_err_hold; !TLV_DONE_O |-> $stable(TLV_ERR_O); endproperty
  a_err_hold: assert property (p_err_hold) else $error("flags moved");
  property p_drop; PKT_DROP_O |-> PKT_READY_O && VIOL_O; endproperty
  a_drop: assert property (p_drop) else $error("drop unreported");
  property p_viol; VIOL_O |-> PKT_DROP_O; endproperty
  a_viol: assert property (p_viol) else $error("violation without drop");
  property p_rdy; PKT_READY_O |-> $past(PKT_VALID_I) ##1 !PKT_READY_O; endproperty
  a_rdy: assert property (p_rdy) else $error("admission unasked");
  // Priority moves only by load or write
  property p_prio;
    $changed(PRIO_O) |-> TLV_DONE_O || $past(TLV_DONE_O) || $past(PREADY_O && PWRITE_I);
  endproperty
  a_prio: assert property (p_prio) else $error("priority moved");
  c_drop: cover property (PKT_DROP_O);
  c_slverr: cover property (PSLVERR_O);
  c_tlv_err: cover property (TLV_DONE_O && TLV_ERR_O != 8'h00);
endmodule
bind rate_limiter rate_limiter_props #(.POLICE_MARGIN(POLICE_MARGIN)) u_rate_limiter_props (
  .CLK_I(CLK_I), .RSTN_I(RSTN_I), .CE_I(CE_I), .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I),
  .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I), .PRDATA_O(PRDATA_O),
  .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O), .TLV_VALID_I(TLV_VALID_I),
  .TLV_DATA_I(TLV_DATA_I), .TLV_LAST_I(TLV_LAST_I), .TLV_DONE_O(TLV_DONE_O),
  .TLV_ERR_O(TLV_ERR_O), .PKT_VALID_I(PKT_VALID_I), .PKT_LEN_I(PKT_LEN_I),
  .PKT_READY_O(PKT_READY_O), .PKT_DROP_O(PKT_DROP_O), .VIOL_O(VIOL_O), .PRIO_O(PRIO_O));
`default_nettype wire

// *** flow_source.sv ***
`timescale 1ns/1ns
`default_nettype none
module flow_source (
  input  wire logic   clk_i,
  input  wire logic   ready_i,  // Admission pulse
  input  wire logic   drop_i,   // Taken but discarded
  output logic        valid_o,  // Item offered
  output logic [15:0] len_o     // Item length
);
  // ************************************************
  // Peer packet source
  // ************************************************
  initial begin
    valid_o = 1'b0;
    len_o = 16'h0;
  end
  // Offer one item, hold it until taken
  task automatic send(input logic [15:0] l, output int waited, output logic dropped);
    waited = 0;
    @(posedge clk_i);
    valid_o <= 1'b1;
    len_o <= l;  // Bytes after header check through CRC
    do begin
      @(posedge clk_i);
      waited++;
    end while (ready_i !== 1'b1);  // Only the bench watchdog ends a lost answer
    dropped = drop_i;
    valid_o <= 1'b0;
    len_o <= ~l;  // Released: stale length inverted
  endtask
endmodule
`default_nettype wire

// *** tb_rate_limiter.sv ***
`timescale 1ns/1ns
`default_nettype none
module tb_rate_limiter;
  import rate_pkg::*;
  // ************************************************
  // Signals and instances
  // ************************************************
  logic clk_i, rstn_i, psel, pen, pwr, prdy, perr, tv, tl, done, pv, rdy, drop, viol, er, dr;
  logic [7:0]  padr, td, terr;
  logic [31:0] pwd, prd, rd;
  logic [15:0] plen;
  logic [2:0]  prio;
  logic [7:0]  q[$];
  int          bad_count, checked, w;
  rate_limiter u_rate_limiter (
    .CLK_I(clk_i), .RSTN_I(rstn_i), .CE_I(1'b1), .PSEL_I(psel), .PENABLE_I(pen),
    .PWRITE_I(pwr), .PADDR_I(padr), .PWDATA_I(pwd), .PRDATA_O(prd), .PREADY_O(prdy),
    .PSLVERR_O(perr), .TLV_VALID_I(tv), .TLV_DATA_I(td), .TLV_LAST_I(tl),
    .TLV_DONE_O(done), .TLV_ERR_O(terr), .PKT_VALID_I(pv), .PKT_LEN_I(plen),
    .PKT_READY_O(rdy), .PKT_DROP_O(drop), .VIOL_O(viol), .PRIO_O(prio));
  flow_source u_flow_source (.clk_i(clk_i), .ready_i(rdy), .drop_i(drop), .valid_o(pv),
    .len_o(plen));
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  // ************************************************
  // Tasks
  // ************************************************
  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  // One APB transfer, waits for the answer
  task automatic apb(input logic wr_, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= wr_;
    padr <= a;
    pwd <= d;
    @(posedge clk_i);
    pen <= 1'b1;
    // Only the bench watchdog ends a lost answer
    do begin
      @(posedge clk_i);
    end while (prdy !== 1'b1);
    rd = prd;
    er = perr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    cmp(nm, e, rd);
  endtask
  // Send one encoding, check flags
  task automatic tlv(input logic [7:0] b[$], input logic [7:0] e);
    foreach (b[i]) begin
      @(posedge clk_i);
      tv <= 1'b1;
      td <= b[i];
      tl <= (i == b.size() - 1);
    end
    @(posedge clk_i);
    tv <= 1'b0;
    tl <= 1'b0;
    td <= ~td;
    @(posedge clk_i);
    cmp("tlv_done", 32'h1, {31'h0, done});
    cmp("tlv_err", {24'h0, e}, {24'h0, terr});
    // Let an autoload land before the caller looks
    @(posedge clk_i);
  endtask
  task automatic end_of_test;
    if (bad_count == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // ************************************************
  // Sequence
  // ************************************************
  initial begin
    {rstn_i, psel, pen, pwr, tv, tl, padr, td, pwd} = '0;
    bad_count = 0;
    checked = 0;
    repeat (20) @(posedge clk_i);
    rstn_i <= 1'b1;
    rdc("ctrl", ADDR_CTRL, 32'h0);
    rdc("rate", ADDR_RATE, 32'h0);
    rdc("burst", ADDR_BURST, BURST_DEF);
    apb(1'b0, 8'h1c, 32'h0);
    cmp("unmapped", 32'h1, {31'h0, er});
    apb(1'b1, ADDR_BURST, 32'h64);
    rdc("burst_min", ADDR_BURST, BURST_MIN);
    // Clamp set; no parse yet, so the parse-ok bit reads one
    rdc("clamp", ADDR_STATUS, 32'h3);
    apb(1'b1, ADDR_CTRL, 32'h1);
    u_flow_source.send(16'hea60, w, dr);
    cmp("no_rate", 32'h2, w);
    apb(1'b1, ADDR_RATE, 32'h0bebc200);  // One byte per cycle
    apb(1'b1, ADDR_BURST, BURST_MIN);
    u_flow_source.send(16'h05f2, w, dr);
    cmp("full_bucket", 32'h2, w);
    u_flow_source.send(16'h0064, w, dr);
    cmp("shaped", 32'h1, {31'h0, (w >= 95 && w <= 110)});
    apb(1'b1, ADDR_CTRL, 32'h3);  // Police mode, refill
    u_flow_source.send(16'h05f2, w, dr);
    cmp("kept", 32'h0, {31'h0, dr});
    u_flow_source.send(16'h03e8, w, dr);
    cmp("dropped", 32'h1, {31'h0, dr});
    rdc("viol", ADDR_VIOL, 32'h1);
    apb(1'b1, ADDR_VIOL, 32'h0);
    rdc("viol_clr", ADDR_VIOL, 32'h0);
    apb(1'b1, ADDR_CTRL, 32'h4);  // Autoload only
    tlv({8'h07, 8'h01, 8'h05}, 8'h00);
    cmp("prio", 32'h5, {29'h0, prio});
    tlv({8'h07, 8'h01, 8'h08}, 8'h40);
    tlv({8'h07, 8'h01, 8'h01, 8'h07, 8'h01, 8'h02}, 8'h02);
    tlv({8'h05, 8'h03, 8'h02, 8'h01, 8'h04}, 8'h04);
    tlv({8'h05, 8'h03, 8'h01, 8'h01, 8'h08}, 8'h08);
    tlv({8'h05, 8'h06, 8'h01, 8'h01, 8'h08, 8'h02, 8'h01, 8'h00}, 8'h10);
    tlv({8'h05, 8'h09, 8'h01, 8'h01, 8'h08, 8'h02, 8'h01, 8'h04, 8'h03, 8'h01, 8'h41},
        8'h20);
    tlv({8'h05, 8'h06, 8'h01, 8'h01, 8'h08, 8'h02, 8'h01, 8'h04, 8'h07, 8'h01, 8'h01},
        8'h80);
    tlv({8'h08, 8'h03, 8'h00, 8'h00, 8'h01}, 8'h40);
    tlv({8'h08, 8'h04, 8'h00, 8'h00, 8'h00, 8'h00}, 8'h00);
    cmp("prio_def", 32'h0, {29'h0, prio});
    rdc("burst_def", ADDR_BURST, BURST_DEF);
    q = {8'h04, 8'hfd};
    repeat (253) q.push_back(8'h41);
    tlv(q, 8'h00);
    q[1] = 8'hfe;
    q.push_back(8'h41);
    tlv(q, 8'h01);
    end_of_test;
  end
  // Hang guard
  initial begin
    repeat (20000) @(posedge clk_i);
    bad_count++;
    end_of_test;
  end
endmodule
`default_nettype wire
